// file: include/scr_pkg.sv
package scr_pkg;

  // Register indices; the bus byte address is four times the index
  localparam logic [7:0]  CTL1_IDX        = 8'hE8;
  localparam logic [7:0]  CTL2_IDX        = 8'hE9;
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] CTL1_ADDR       = {2'h0, CTL1_IDX, 2'h0};
  localparam logic [11:0] CTL2_ADDR       = {2'h0, CTL2_IDX, 2'h0};

  // serial_control_one fields
  localparam int          B_XFER_IRQ_EN   = 7;
  localparam int          B_SYS_EN        = 6;
  localparam int          B_TXE_IRQ_EN    = 5;
  localparam int          B_ROLE          = 4;
  localparam int          B_POL           = 3;
  localparam int          B_PHA           = 2;
  localparam int          B_SEL_OE        = 1;
  localparam int          B_LOW_FIRST     = 0;

  // serial_control_two fields
  localparam int          B_FAULT_EN      = 4;
  localparam int          B_SW_OE         = 3;
  localparam int          B_WAIT_STOP     = 1;
  localparam int          B_PIN_CTL       = 0;

  localparam logic [7:0]  CTL1_RST        = 8'h00;
  localparam logic [7:0]  CTL2_RST        = 8'h00;
  localparam logic [7:0]  CTL2_WMASK      = 8'h1B;
  // Bits whose change aborts a master transfer
  localparam logic [7:0]  CTL1_ABORT_MASK = 8'h0F;
  localparam logic [7:0]  CTL2_ABORT_MASK = 8'h11;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

// file: hw/scr_control.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps

module scr_control
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [scr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [scr_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      wait_mode,
  input  wire logic                      transfer_done_flag,
  input  wire logic                      tx_empty_flag,
  input  wire logic                      mode_fault_flag,
  input  wire logic                      xfer_busy,
  input  wire logic [7:0]                tx_byte,
  input  wire logic                      sck_pin,
  input  wire logic                      ss_n_pin,
  output logic                           xfer_irq_q,
  output logic                           tx_irq_q,
  output logic                           force_idle_q,
  output logic                           flags_clear_q,
  output logic                           pins_owned_q,
  output logic                           role_master_q,
  output logic                           clk_idle_high_q,
  output logic                           sample_even_q,
  output logic                           clk_gen_run_q,
  output logic [7:0]                     shift_byte_q,
  output logic                           mosi_oe_q,
  output logic                           miso_oe_q,
  output logic                           rx_from_mosi_q,
  output logic                           ss_n_out_q,
  output logic                           ss_oe_q,
  output logic                           mode_fault_evt_q,
  output logic                           slave_sample_q,
  output logic                           slave_shift_q
);

  logic [7:0]  ctl1_q, ctl1_d, ctl2_q, ctl2_d;
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [11:0] waddr_q, waddr_d;
  logic [7:0]  wbyte_q, wbyte_d;
  logic        wlane_q, wlane_d;
  logic        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]  bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic        force_idle_d;
  logic        do_write;

  // Bus side and control registers
  always_comb
  begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    waddr_d   = waddr_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bvalid_d  = s_axi_bvalid;
    bresp_d   = s_axi_bresp;
    rvalid_d  = s_axi_rvalid;
    rresp_d   = s_axi_rresp;
    rdata_d   = s_axi_rdata;
    ctl1_d    = ctl1_q;
    ctl2_d    = ctl2_q;
    do_write  = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_d = 1'b1;
      waddr_d   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_d = 1'b1;
      wbyte_d  = s_axi_wdata[7:0];
      wlane_d  = s_axi_wstrb[0];
    end
    if (aw_have_q && w_have_q && !s_axi_bvalid)
    begin
      do_write  = 1'b1;
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = scr_pkg::RESP_OKAY;
      // Writable at any time; reserved bits of the second never stored
      if (waddr_q == scr_pkg::CTL1_ADDR)
      begin
        if (wlane_q)
          ctl1_d = wbyte_q;
      end
      else if (waddr_q == scr_pkg::CTL2_ADDR)
      begin
        if (wlane_q)
          ctl2_d = wbyte_q & scr_pkg::CTL2_WMASK;
      end
      else
        bresp_d = scr_pkg::RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      bvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d  = scr_pkg::RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      if (s_axi_araddr == scr_pkg::CTL1_ADDR)
        rdata_d[7:0] = ctl1_q;
      else if (s_axi_araddr == scr_pkg::CTL2_ADDR)
        rdata_d[7:0] = ctl2_q;
      else
        rresp_d = scr_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      rvalid_d = 1'b0;
    // One write and one read at a time keeps the slave free of queues
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
    // Disable, role change, or master reconfiguration sends shifter idle
    force_idle_d =
      (ctl1_q[scr_pkg::B_SYS_EN] && !ctl1_d[scr_pkg::B_SYS_EN])
      || (ctl1_q[scr_pkg::B_ROLE] != ctl1_d[scr_pkg::B_ROLE])
      || (ctl1_q[scr_pkg::B_ROLE]
          && (((ctl1_q ^ ctl1_d) & scr_pkg::CTL1_ABORT_MASK) != 8'h00
           || ((ctl2_q ^ ctl2_d) & scr_pkg::CTL2_ABORT_MASK) != 8'h00))
      || (ctl1_q[scr_pkg::B_ROLE] && ctl2_q[scr_pkg::B_PIN_CTL]
          && ctl2_q[scr_pkg::B_SW_OE] != ctl2_d[scr_pkg::B_SW_OE]);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl1_q        <= scr_pkg::CTL1_RST;
      ctl2_q        <= scr_pkg::CTL2_RST;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      waddr_q       <= 12'h000;
      wbyte_q       <= 8'h00;
      wlane_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0000_0000;
      force_idle_q  <= 1'b0;
    end
    else
    begin
      ctl1_q        <= ctl1_d;
      ctl2_q        <= ctl2_d;
      aw_have_q     <= aw_have_d;
      w_have_q      <= w_have_d;
      waddr_q       <= waddr_d;
      wbyte_q       <= wbyte_d;
      wlane_q       <= wlane_d;
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rresp   <= rresp_d;
      s_axi_rdata   <= rdata_d;
      force_idle_q  <= force_idle_d;
    end
  end

  // Pin synchronisers and pin steering
  logic       sck_s1_q, sck_s2_q, sck_s3_q, ss_s1_q, ss_s2_q;
  logic       en, mst, pinc, swoe, fen, lead, trail, slave_sel;
  logic       xfer_irq_d, tx_irq_d, run_d, mosi_oe_d, miso_oe_d, rxm_d;
  logic       ss_oe_d, fault_d, samp_d, shift_d;
  logic [7:0] order_d;

  // Reversal happens only on the shifter path, never in the register
  for (genvar i = 0; i < 8; i++)
  begin : g_order
    assign order_d[i] = ctl1_q[scr_pkg::B_LOW_FIRST] ? tx_byte[7-i]
                                                     : tx_byte[i];
  end

  always_comb
  begin
    en    = ctl1_q[scr_pkg::B_SYS_EN];
    mst   = ctl1_q[scr_pkg::B_ROLE];
    pinc  = ctl2_q[scr_pkg::B_PIN_CTL];
    swoe  = ctl2_q[scr_pkg::B_SW_OE];
    fen   = ctl2_q[scr_pkg::B_FAULT_EN];
    xfer_irq_d = ctl1_q[scr_pkg::B_XFER_IRQ_EN]
                 && (transfer_done_flag || mode_fault_flag);
    tx_irq_d   = ctl1_q[scr_pkg::B_TXE_IRQ_EN] && tx_empty_flag;
    // Slave is never gated by wait so it stays aligned to its master
    run_d = en && mst
            && !(wait_mode && ctl2_q[scr_pkg::B_WAIT_STOP]);
    mosi_oe_d = en && mst && (!pinc || swoe);
    miso_oe_d = en && !mst && (!pinc || swoe);
    rxm_d     = mst ? pinc : !pinc;
    ss_oe_d   = en && mst && fen
                && ctl1_q[scr_pkg::B_SEL_OE];
    fault_d   = en && mst && fen && !ctl1_q[scr_pkg::B_SEL_OE]
                && !ss_s2_q;
    // Leading edge leaves the idle level, trailing edge returns to it
    lead  = (sck_s2_q != ctl1_q[scr_pkg::B_POL])
            && (sck_s3_q == ctl1_q[scr_pkg::B_POL]);
    trail = (sck_s2_q == ctl1_q[scr_pkg::B_POL])
            && (sck_s3_q != ctl1_q[scr_pkg::B_POL]);
    slave_sel = en && !mst && !ss_s2_q;
    samp_d  = slave_sel && (ctl1_q[scr_pkg::B_PHA] ? trail : lead);
    shift_d = slave_sel && (ctl1_q[scr_pkg::B_PHA] ? lead : trail);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_s1_q         <= 1'b0;
      sck_s2_q         <= 1'b0;
      sck_s3_q         <= 1'b0;
      ss_s1_q          <= 1'b1;
      ss_s2_q          <= 1'b1;
      xfer_irq_q       <= 1'b0;
      tx_irq_q         <= 1'b0;
      flags_clear_q    <= 1'b1;
      pins_owned_q     <= 1'b0;
      role_master_q    <= 1'b0;
      clk_idle_high_q  <= 1'b0;
      sample_even_q    <= 1'b0;
      clk_gen_run_q    <= 1'b0;
      shift_byte_q     <= 8'h00;
      mosi_oe_q        <= 1'b0;
      miso_oe_q        <= 1'b0;
      rx_from_mosi_q   <= 1'b0;
      ss_n_out_q       <= 1'b1;
      ss_oe_q          <= 1'b0;
      mode_fault_evt_q <= 1'b0;
      slave_sample_q   <= 1'b0;
      slave_shift_q    <= 1'b0;
    end
    else
    begin
      sck_s1_q         <= sck_pin;
      sck_s2_q         <= sck_s1_q;
      sck_s3_q         <= sck_s2_q;
      ss_s1_q          <= ss_n_pin;
      ss_s2_q          <= ss_s1_q;
      xfer_irq_q       <= xfer_irq_d;
      tx_irq_q         <= tx_irq_d;
      flags_clear_q    <= !en;
      pins_owned_q     <= en;
      role_master_q    <= mst;
      clk_idle_high_q  <= ctl1_q[scr_pkg::B_POL];
      sample_even_q    <= ctl1_q[scr_pkg::B_PHA];
      clk_gen_run_q    <= run_d;
      shift_byte_q     <= order_d;
      mosi_oe_q        <= mosi_oe_d;
      miso_oe_q        <= miso_oe_d;
      rx_from_mosi_q   <= rxm_d;
      ss_n_out_q       <= !xfer_busy;
      ss_oe_q          <= ss_oe_d;
      mode_fault_evt_q <= fault_d;
      slave_sample_q   <= samp_d;
      slave_shift_q    <= shift_d;
    end
  end

  sequence s_role_flip;
    $changed(ctl1_q[scr_pkg::B_ROLE]);
  endsequence

  sequence s_disable;
    $fell(ctl1_q[scr_pkg::B_SYS_EN]);
  endsequence

  AST_XFER_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    xfer_irq_q |-> $past(ctl1_q[scr_pkg::B_XFER_IRQ_EN])
      && $past(transfer_done_flag || mode_fault_flag))
    else $error("transfer irq without enable and flag");

  AST_DISABLE_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_disable |-> force_idle_q ##1 flags_clear_q && !pins_owned_q)
    else $error("disable did not idle and clear flags");

  AST_TX_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl1_q[scr_pkg::B_TXE_IRQ_EN] && tx_empty_flag |=> tx_irq_q)
    else $error("tx empty irq missing");

  AST_ROLE_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_role_flip |-> force_idle_q ##1 role_master_q == ctl1_q[scr_pkg::B_ROLE])
    else $error("role change did not idle");

  AST_MASTER_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ctl1_q[scr_pkg::B_ROLE])
      && ((ctl1_q ^ $past(ctl1_q)) & scr_pkg::CTL1_ABORT_MASK) != 8'h00
      |-> force_idle_q)
    else $error("master reconfiguration did not abort");

  AST_SEL_PIN: assert property (@(posedge aclk) disable iff (!aresetn)
    ss_oe_q |-> $past(ctl1_q[scr_pkg::B_ROLE] && ctl2_q[scr_pkg::B_FAULT_EN]
      && ctl1_q[scr_pkg::B_SEL_OE]))
    else $error("select driven outside master output setting");

  AST_MASTER_BIDIR: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctl1_q[scr_pkg::B_ROLE] && ctl2_q[scr_pkg::B_PIN_CTL]) [*2]
      |-> rx_from_mosi_q && !miso_oe_q)
    else $error("master single-wire pins wrong");

  AST_WAIT_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
    wait_mode && ctl2_q[scr_pkg::B_WAIT_STOP] |=> !clk_gen_run_q)
    else $error("clock ran in wait with stop set");

  AST_RSVD_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctl2_q & ~scr_pkg::CTL2_WMASK) == 8'h00 && s_axi_rdata[31:8] == 24'h0)
    else $error("reserved bits not zero");

endmodule

// file: tb/scr_peer.sv
`timescale 1ns/1ps
module scr_peer
(
  input  wire logic go,
  input  wire logic pol,
  input  wire logic hold_sel,
  output logic      sck,
  output logic      ss_n,
  output logic      busy
);
  logic in_frame;
  initial
  begin
    in_frame = 1'b0;
    busy = 1'b0;
    sck = 1'b0;
  end
  // Idle level follows the shared polarity setting
  always @(pol)
    if (!in_frame)
      sck = pol;
  // Select has a pull-up, so a released line reads high
  assign ss_n = !(in_frame || hold_sel);
  // Clock stands still outside frames; odd phase to the bus clock
  always @(posedge go)
  begin
    busy = 1'b1;
    #37;
    in_frame = 1'b1;
    #160;
    repeat (16)
    begin
      sck = !sck;
      #160;
    end
    in_frame = 1'b0;
    #160;
    busy = 1'b0;
  end
endmodule

// file: tb/scr_control_tb.sv
`timescale 1ns/1ps
module scr_control_tb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [1:0]  bresp, rresp, last_resp, rd_resp;
  logic [7:0]  tx, sbyte, c1s [6], c2s [6];
  logic [4:0]  exps [6];
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        wait_mode, done_f, txe_f, fault_f, busy_in, sck, ss_n;
  logic        xirq, tirq, fidle, fclr, pown, rmas, cpol, cpha, crun;
  logic        mosi_oe, miso_oe, rxm, ssn_o, ss_oe, mfe, ssamp, sshift;
  logic        go, pol, hold, pbusy, last_fi;
  int          num_errors, num_checks, n_samp, n_shift, s0, s1;

  scr_control u_scr_control
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .wait_mode(wait_mode),
    .transfer_done_flag(done_f), .tx_empty_flag(txe_f),
    .mode_fault_flag(fault_f), .xfer_busy(busy_in), .tx_byte(tx),
    .sck_pin(sck), .ss_n_pin(ss_n), .xfer_irq_q(xirq), .tx_irq_q(tirq),
    .force_idle_q(fidle), .flags_clear_q(fclr), .pins_owned_q(pown),
    .role_master_q(rmas), .clk_idle_high_q(cpol), .sample_even_q(cpha),
    .clk_gen_run_q(crun), .shift_byte_q(sbyte), .mosi_oe_q(mosi_oe),
    .miso_oe_q(miso_oe), .rx_from_mosi_q(rxm), .ss_n_out_q(ssn_o),
    .ss_oe_q(ss_oe), .mode_fault_evt_q(mfe), .slave_sample_q(ssamp),
    .slave_shift_q(sshift)
  );

  scr_peer u_scr_peer
  (
    .go(go), .pol(pol), .hold_sel(hold), .sck(sck), .ss_n(ss_n),
    .busy(pbusy)
  );

  always #20 aclk = !aclk;

  always @(posedge aclk)
  begin
    n_samp <= n_samp + int'(ssamp);
    n_shift <= n_shift + int'(sshift);
  end

  task automatic close_out;
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h",
               $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    while (!bvalid)
      @(posedge aclk);
    last_fi = fidle;
    last_resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (!arready)
      @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (!rvalid)
      @(posedge aclk);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = v[7-i];
    return r;
  endfunction

  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {wait_mode, done_f, txe_f, fault_f, busy_in, go, pol, hold} = '0;
    {awaddr, araddr, wdata} = '0;
    {num_errors, num_checks, n_samp, n_shift} = '0;
    tx = 8'h1E;
    c1s = '{8'h50, 8'h50, 8'h50, 8'h40, 8'h40, 8'h40};
    c2s = '{8'h00, 8'h01, 8'h09, 8'h00, 8'h01, 8'h09};
    exps = '{5'h04, 5'h01, 5'h1D, 5'h03, 5'h00, 5'h12};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    chk(fclr, 1'b1);
    rd(scr_pkg::CTL1_ADDR);
    chk(rd_data, 32'h00000000);
    wr(scr_pkg::CTL2_ADDR, 8'hE4);
    rd(scr_pkg::CTL2_ADDR);
    chk(rd_data, 32'h00000000);
    wr(12'h000, 8'h55);
    chk(last_resp, scr_pkg::RESP_SLVERR);
    rd(12'h000);
    chk(rd_resp, scr_pkg::RESP_SLVERR);
    chk(rd_data, 32'h0);
    wr(scr_pkg::CTL1_ADDR, 8'h50);
    chk(last_fi, 1'b1);
    tick(2);
    chk({pown, fclr, rmas}, 3'h5);
    done_f <= 1'b1;
    wr(scr_pkg::CTL1_ADDR, 8'hD0);
    chk(last_fi, 1'b0);
    tick(2);
    chk(xirq, 1'b1);
    done_f <= 1'b0;
    fault_f <= 1'b1;
    tick(3);
    chk(xirq, 1'b1);
    fault_f <= 1'b0;
    txe_f <= 1'b1;
    tick(3);
    chk({xirq, tirq}, 2'h0);
    wr(scr_pkg::CTL1_ADDR, 8'hF0);
    tick(2);
    chk(tirq, 1'b1);
    pol <= 1'b1;
    wr(scr_pkg::CTL1_ADDR, 8'h5C);
    chk(last_fi, 1'b1);
    tick(2);
    chk({cpol, cpha}, 2'h3);
    wr(scr_pkg::CTL1_ADDR, 8'h5C);
    chk(last_fi, 1'b0);
    wr(scr_pkg::CTL1_ADDR, 8'h5D);
    tick(2);
    chk(sbyte, rev8(tx));
    wr(scr_pkg::CTL1_ADDR, 8'h5E);
    tick(2);
    chk({sbyte, ss_oe}, {tx, 1'b0});
    wr(scr_pkg::CTL2_ADDR, 8'h10);
    chk(last_fi, 1'b1);
    busy_in <= 1'b1;
    tick(2);
    chk({ss_oe, ssn_o}, 2'h2);
    busy_in <= 1'b0;
    wr(scr_pkg::CTL1_ADDR, 8'h5C);
    hold <= 1'b1;
    tick(6);
    chk({ss_oe, mfe}, 2'h1);
    hold <= 1'b0;
    wr(scr_pkg::CTL1_ADDR, 8'h4E);
    chk(last_fi, 1'b1);
    tick(2);
    chk({ss_oe, mfe}, 2'h0);
    for (int i = 0; i < 6; i++)
    begin
      wr(scr_pkg::CTL1_ADDR, c1s[i]);
      wr(scr_pkg::CTL2_ADDR, c2s[i]);
      if (exps[i][4])
        chk(last_fi, exps[i][3]);
      tick(2);
      chk({mosi_oe, miso_oe, rxm}, exps[i][2:0]);
    end
    pol <= 1'b0;
    wr(scr_pkg::CTL1_ADDR, 8'h50);
    wr(scr_pkg::CTL2_ADDR, 8'h02);
    wait_mode <= 1'b1;
    tick(3);
    chk(crun, 1'b0);
    wait_mode <= 1'b0;
    tick(3);
    chk(crun, 1'b1);
    wr(scr_pkg::CTL2_ADDR, 8'h00);
    wait_mode <= 1'b1;
    tick(3);
    chk(crun, 1'b1);
    wr(scr_pkg::CTL1_ADDR, 8'h40);
    wr(scr_pkg::CTL2_ADDR, 8'h02);
    tick(4);
    s0 = n_samp;
    s1 = n_shift;
    go <= 1'b1;
    tick(2);
    while (pbusy)
      @(posedge aclk);
    go <= 1'b0;
    tick(8);
    chk(n_samp - s0, 8);
    chk(n_shift - s1, 8);
    wr(scr_pkg::CTL1_ADDR, 8'h00);
    chk(last_fi, 1'b1);
    tick(2);
    chk({pown, fclr}, 2'h1);
    close_out();
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    close_out();
  end
endmodule
